// File: core/pdh_dev.sv
// Functional notes
// RULE1: AEN high blocks ports 320h-323h
// RULE2: Decode A0-A9 for four ports
// RULE3: Full 20-bit ROM decode ignoring AEN
// RULE4: Host fetches ROM byte with MEMR
// RULE5: Assert DRQ3 when byte ready
// RULE6: DMA answers DRQ3 with DACK3
// RULE7: DACK3 transfer uses strobes only
// RULE8: IOW strobe writes byte to device
// RULE9: IOR strobe reads byte from device
// RULE10: Data bus tri-stated unless returning byte
// RULE11: Bus carries data, command, status, config
// RULE12: Reset returns to power-up state
// RULE13: Completion interrupt, level 5 or 2
// RULE14: Drop DRQ3 after DMA byte done
`include "pdh_defines.svh"
`default_nettype none
module pdh_dev
    import pdh_pkg::*;
#(
    parameter int ROM_DEPTH = 4096
)(
    input  wire logic       clk,
    input  wire logic       rst,
    pdh_bus_if.dev          bus,
    input  wire logic       irq_sel2,
    input  wire logic [7:0] cfg_in,
    input  wire logic       cmd_done,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_byte,
    output logic            rd_taken,
    output logic            wr_valid,
    output logic [7:0]      wr_byte,
    output logic            cmd_valid,
    output logic [7:0]      cmd_byte,
    output logic            dma_mode
);
    // Blank image here; a build preloads the real contents
    logic [7:0] rom [ROM_DEPTH];
    initial for (int i = 0; i < ROM_DEPTH; i++) rom[i] = 8'h00;

    logic       io_sel, rom_sel, dma_sel, ior_a, iow_a, memr_a;
    logic [1:0] port;
    logic       ior_q, ior_d, iow_q, iow_d, irq_q, irq_d, dma_q, dma_d;
    logic       drq_q, drq_d, busy_q, busy_d;
    logic [7:0] dout_q, dout_d;
    logic       oe_q, oe_d;
    logic       wv_d, cv_d, rt_d;
    logic [7:0] wb_d, cb_d;

    assign ior_a  = !bus.ior_n;
    assign iow_a  = !bus.iow_n;
    assign memr_a = !bus.memr_n;
    assign io_sel = !bus.aen && ((bus.addr[9:0] & `PDH_IO_MASK) == `PDH_IO_BASE); // [RULE1] [RULE2]
    assign port   = bus.addr[1:0];
    assign rom_sel = (bus.addr >= `PDH_ROM_BASE) && (bus.addr <= `PDH_ROM_LAST); // [RULE3]
    assign dma_sel = !bus.dack3_n; // [RULE7]

    // Registered copy of a strobe turns its held level into one action
    function automatic logic strobe_rise(input logic now_a, input logic was_a);
        return now_a && !was_a;
    endfunction

    // Drive priority: ROM window, then DMA acknowledge, then ports
    always_comb
    begin
        ior_d  = ior_a;
        iow_d  = iow_a;
        dout_d = dout_q;
        oe_d   = 1'b0;
        // Data output held from the cycle after strobe start; rise-edge detection gives one action per strobe
        if (memr_a && rom_sel)
        begin
            oe_d   = 1'b1; // [RULE10]
            dout_d = rom[bus.addr[`PDH_ROM_AW-1:0]];
        end
        else if (ior_a && dma_sel)
        begin
            oe_d   = 1'b1; // [RULE7] [RULE9]
            dout_d = rd_byte;
        end
        else if (ior_a && io_sel)
        begin
            oe_d = 1'b1; // [RULE9] [RULE11]
            unique case (port)
                `PDH_PORT_DATA:   dout_d = rd_byte;
                `PDH_PORT_STATUS: dout_d = {5'h00, busy_q, drq_q, irq_q};
                `PDH_PORT_CMD:    dout_d = {7'h00, dma_q};
                `PDH_PORT_CFG:    dout_d = cfg_in;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ior_q  <= 1'b0; // [RULE12]
            iow_q  <= 1'b0;
            dout_q <= 8'h00;
            oe_q   <= 1'b0;
        end
        else
        begin
            ior_q  <= ior_d;
            iow_q  <= iow_d;
            dout_q <= dout_d;
            oe_q   <= oe_d;
        end
    end

    always_comb
    begin
        dma_d  = dma_q;
        busy_d = busy_q;
        irq_d  = irq_q;
        drq_d  = drq_q;
        wv_d   = 1'b0;
        cv_d   = 1'b0;
        rt_d   = 1'b0;
        wb_d   = wr_byte;
        cb_d   = cmd_byte;
        if (strobe_rise(ior_a, ior_q) && (dma_sel || (io_sel && port == `PDH_PORT_DATA)))
        begin
            rt_d = 1'b1;
            if (dma_sel)
                drq_d = 1'b0; // [RULE14]
        end
        if (strobe_rise(iow_a, iow_q))
        begin
            if (dma_sel)
            begin
                wv_d  = 1'b1; // [RULE7] [RULE8]
                wb_d  = bus.data;
                drq_d = 1'b0; // [RULE14]
            end
            else if (io_sel)
            begin
                unique case (port)
                    `PDH_PORT_DATA:
                    begin
                        wv_d = 1'b1; // [RULE8] [RULE11]
                        wb_d = bus.data;
                    end
                    `PDH_PORT_CMD:
                    begin
                        cv_d   = 1'b1; // [RULE11]
                        cb_d   = bus.data;
                        dma_d  = bus.data[0];
                        busy_d = 1'b1;
                        irq_d  = 1'b0;
                    end
                    default:
                    begin
                        irq_d = 1'b0;
                    end
                endcase
            end
        end
        // Re-request only once the previous acknowledge has gone away
        if (dma_q && rd_valid && !dma_sel && !rt_d)
            drq_d = 1'b1; // [RULE5]
        // Completion comes last, so a same-cycle clear loses to the set
        if (cmd_done)
        begin
            irq_d  = 1'b1; // [RULE13]
            busy_d = 1'b0;
            dma_d  = 1'b0;
            drq_d  = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_q     <= 1'b0; // [RULE12]
            dma_q     <= 1'b0;
            drq_q     <= 1'b0;
            busy_q    <= 1'b0;
            wr_valid  <= 1'b0;
            wr_byte   <= 8'h00;
            cmd_valid <= 1'b0;
            cmd_byte  <= 8'h00;
            rd_taken  <= 1'b0;
        end
        else
        begin
            irq_q     <= irq_d;
            dma_q     <= dma_d;
            drq_q     <= drq_d;
            busy_q    <= busy_d;
            wr_valid  <= wv_d;
            wr_byte   <= wb_d;
            cmd_valid <= cv_d;
            cmd_byte  <= cb_d;
            rd_taken  <= rt_d;
        end
    end

    assign bus.dev_d_o  = dout_q;
    assign bus.dev_d_oe = oe_q; // [RULE10]
    assign bus.drq3     = drq_q;
    // Jumper picks one level; the other line stays low
    assign bus.irq5     = irq_q && !irq_sel2; // [RULE13]
    assign bus.irq2     = irq_q && irq_sel2;  // [RULE13]
    assign dma_mode     = dma_q;
endmodule
`default_nettype wire

// File: core/pdh_defines.svh
`ifndef PDH_DEFINES_SVH
`define PDH_DEFINES_SVH
`define PDH_IO_BASE      10'h320
`define PDH_IO_MASK      10'h3FC
`define PDH_ROM_BASE     20'hC_8000
`define PDH_ROM_LAST     20'hC_8FFF
`define PDH_ROM_AW       12
`define PDH_PORT_DATA    2'h0
`define PDH_PORT_STATUS  2'h1
`define PDH_PORT_CMD     2'h2
`define PDH_PORT_CFG     2'h3
`define PDH_STAT_IRQ     0
`define PDH_STAT_DRQ     1
`define PDH_STAT_BUSY    2
`endif

// File: core/pdh_pkg.sv
`default_nettype none
package pdh_pkg;
    typedef enum logic [1:0] {PDH_H_IDLE, PDH_H_STROBE, PDH_H_DONE} pdh_hstate_t;
    typedef enum logic [1:0] {PDH_OP_IOR, PDH_OP_IOW, PDH_OP_MEMR, PDH_OP_DMA} pdh_op_t;
endpackage
`default_nettype wire

// File: core/pdh_bus_if.sv
`default_nettype none
interface pdh_bus_if;
    logic [19:0] addr;
    logic        aen;
    logic        memr_n;
    logic        ior_n;
    logic        iow_n;
    logic        dack3_n;
    logic        drq3;
    logic        irq2;
    logic        irq5;
    logic [7:0]  dev_d_o;
    logic        dev_d_oe;
    logic [7:0]  host_d_o;
    logic        host_d_oe;
    logic [7:0]  data;
    assign data = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : 8'hFF);
    modport dev  (input addr, aen, memr_n, ior_n, iow_n, dack3_n, data,
                  output drq3, irq2, irq5, dev_d_o, dev_d_oe);
    modport host (output addr, aen, memr_n, ior_n, iow_n, dack3_n, host_d_o, host_d_oe,
                  input drq3, irq2, irq5, data);
endinterface
`default_nettype wire

// File: core/pdh_host.sv
`include "pdh_defines.svh"
`default_nettype none
module pdh_host
    import pdh_pkg::*;
#(
    parameter int STROBE_CYC = 4
)(
    input  wire logic        clk,
    input  wire logic        rst,
    pdh_bus_if.host          bus,
    input  wire logic        req_valid,
    input  wire pdh_op_t     req_op,
    input  wire logic [19:0] req_addr,
    input  wire logic [7:0]  req_wdata,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic [7:0]       rsp_data,
    output logic             irq_seen,
    output logic             drq_seen
);
    pdh_hstate_t st_q, st_d;
    pdh_op_t     op_q, op_d;
    logic [19:0] a_q, a_d;
    logic [7:0]  w_q, w_d, r_q, r_d;
    logic [3:0]  cnt_q, cnt_d;
    logic        rv_d;

    always_comb
    begin
        st_d  = st_q;
        op_d  = op_q;
        a_d   = a_q;
        w_d   = w_q;
        r_d   = r_q;
        cnt_d = cnt_q;
        rv_d  = 1'b0;
        unique case (st_q)
            PDH_H_IDLE:
            begin
                if (req_valid)
                begin
                    st_d  = PDH_H_STROBE;
                    op_d  = req_op;
                    a_d   = req_addr;
                    w_d   = req_wdata;
                    cnt_d = 4'(STROBE_CYC);
                end
            end
            PDH_H_STROBE:
            begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1)
                begin
                    r_d  = bus.data; // [RULE4] [RULE9]
                    st_d = PDH_H_DONE;
                end
            end
            PDH_H_DONE:
            begin
                rv_d = 1'b1;
                st_d = PDH_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q      <= PDH_H_IDLE;
            op_q      <= PDH_OP_IOR;
            a_q       <= 20'h0_0000;
            w_q       <= 8'h00;
            r_q       <= 8'h00;
            cnt_q     <= 4'h0;
            rsp_valid <= 1'b0;
        end
        else
        begin
            st_q      <= st_d;
            op_q      <= op_d;
            a_q       <= a_d;
            w_q       <= w_d;
            r_q       <= r_d;
            cnt_q     <= cnt_d;
            rsp_valid <= rv_d;
        end
    end

    logic act, dma_op, other_ch;
    assign act       = (st_q == PDH_H_STROBE);
    assign dma_op    = (op_q == PDH_OP_DMA);
    // a_q[1] in a DMA op: another channel's cycle, AEN without DACK3;
    // its write pairs with MEMR, as a memory-to-port transfer would
    assign other_ch  = dma_op && a_q[1];
    assign req_ready = (st_q == PDH_H_IDLE);
    assign rsp_data  = r_q;
    assign bus.addr     = a_q;
    assign bus.aen      = act && dma_op;
    assign bus.memr_n   = !(act && (op_q == PDH_OP_MEMR || (other_ch && a_q[0]))); // [RULE4]
    // DMA op: a_q[0] chooses write (IOW) versus read (IOR)
    assign bus.ior_n    = !(act && (op_q == PDH_OP_IOR || (dma_op && !a_q[0]))); // [RULE9]
    assign bus.iow_n    = !(act && (op_q == PDH_OP_IOW || (dma_op && a_q[0]))); // [RULE8]
    assign bus.dack3_n  = !(act && dma_op && !a_q[1]); // [RULE6]
    assign bus.host_d_o  = w_q;
    // Memory owns the data lines while MEMR is low
    assign bus.host_d_oe = act && !bus.iow_n && bus.memr_n;
    assign irq_seen = bus.irq2 || bus.irq5;
    assign drq_seen = bus.drq3;
endmodule
`default_nettype wire

// File: bench/pdh_bus_monitor.sv
`default_nettype none
module pdh_bus_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [19:0] addr,
    input wire logic        aen,
    input wire logic        memr_n,
    input wire logic        ior_n,
    input wire logic        iow_n,
    input wire logic        dack3_n,
    input wire logic        drq3,
    input wire logic        irq2,
    input wire logic        irq5,
    input wire logic [7:0]  dev_d_o,
    input wire logic        dev_d_oe,
    input wire logic        host_d_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Drive tail lasts one cycle, so idle checks span three
    wire logic io_hit = addr[9:2] == 8'hC8;
    wire logic rom_hit = addr[19:12] == 8'hC8;
    a_aen_blocks_io: assert property ((aen && dack3_n && memr_n)[*3] |-> !dev_d_oe)
        else $error("port answered with aen high");
    a_io_decode_hit: assert property (!aen && dack3_n && io_hit && $fell(ior_n)
        |-> ##[1:2] dev_d_oe)
        else $error("port read not driven");
    a_io_unmapped: assert property ((!io_hit && memr_n && dack3_n)[*3] |-> !dev_d_oe)
        else $error("unmapped port driven");
    a_rom_any_aen: assert property ($fell(memr_n) && rom_hit |-> ##[1:2] dev_d_oe)
        else $error("rom read not driven");
    a_rom_byte_value: assert property (!memr_n && dev_d_oe && rom_hit |-> dev_d_o == 8'h00)
        else $error("rom byte wrong");
    a_dma_bypass: assert property (!dack3_n && $fell(ior_n) |-> ##[1:2] dev_d_oe)
        else $error("dma read not driven");
    a_bus_release: assert property ((ior_n && memr_n)[*3] |-> !dev_d_oe)
        else $error("bus held when idle");
    a_no_bus_fight: assert property (!(dev_d_oe && host_d_oe))
        else $error("both ends drive data");
    a_irq_one_line: assert property (!(irq2 && irq5))
        else $error("both irq lines high");
    a_drq_drop_dma: assert property (!dack3_n && $fell(ior_n && iow_n) |-> ##[1:2] !drq3)
        else $error("drq held after dma strobe");
    a_reset_quiet: assert property ($fell(rst) |-> !drq3 && !irq2 && !irq5 && !dev_d_oe)
        else $error("outputs active after reset");
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`default_nettype none
module tb_top
    import pdh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, req_valid, req_ready, rsp_valid, irq_seen, drq_seen, irq_sel2;
    logic        cmd_done, rd_valid, rd_taken, wr_valid, cmd_valid, dma_mode;
    pdh_op_t     req_op;
    logic [19:0] req_addr;
    logic [7:0]  req_wdata, rsp_data, cfg_in, rd_byte, wr_byte, cmd_byte, got, last_wr, last_cmd;
    int          n_mismatch, n_tests, cyc;
    pdh_bus_if bus_if ();
    pdh_dev pdh_dev_inst (.clk, .rst, .bus(bus_if), .irq_sel2, .cfg_in, .cmd_done, .rd_valid,
        .rd_byte, .rd_taken, .wr_valid, .wr_byte, .cmd_valid, .cmd_byte, .dma_mode);
    pdh_host pdh_host_inst (.clk, .rst, .bus(bus_if), .req_valid, .req_op, .req_addr,
        .req_wdata, .req_ready, .rsp_valid, .rsp_data, .irq_seen, .drq_seen);
    pdh_bus_monitor pdh_bus_monitor_inst (.clk, .rst, .addr(bus_if.addr), .aen(bus_if.aen),
        .memr_n(bus_if.memr_n), .ior_n(bus_if.ior_n), .iow_n(bus_if.iow_n),
        .dack3_n(bus_if.dack3_n), .drq3(bus_if.drq3), .irq2(bus_if.irq2), .irq5(bus_if.irq5),
        .dev_d_o(bus_if.dev_d_o), .dev_d_oe(bus_if.dev_d_oe), .host_d_oe(bus_if.host_d_oe));
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (wr_valid === 1'h1)
            last_wr <= wr_byte;
        if (cmd_valid === 1'h1)
            last_cmd <= cmd_byte;
        if (cyc == 5000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end
    // Consumer side: a taken byte leaves no second byte behind
    always @(negedge clk)
        if (rd_taken === 1'h1)
            rd_valid = 1'h0;
    task automatic print_verdict();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic xfer(input pdh_op_t op, input logic [19:0] a, input logic [7:0] w);
        got = 8'hxx;
        while (req_ready !== 1'h1)
            @(negedge clk);
        req_valid = 1'h1;
        req_op = op;
        req_addr = a;
        req_wdata = w;
        @(negedge clk);
        req_valid = 1'h0;
        for (int i = 0; i < 20; i++)
        begin
            @(negedge clk);
            if (rsp_valid === 1'h1)
            begin
                got = rsp_data;
                break;
            end
        end
        @(negedge clk);
    endtask
    task automatic done_pulse();
        cmd_done = 1'h1;
        @(negedge clk);
        cmd_done = 1'h0;
        repeat (2) @(negedge clk);
    endtask
    task automatic t_ports();
        chk({4'h0, bus_if.drq3, bus_if.irq2, bus_if.irq5, bus_if.dev_d_oe}, 8'h00);
        xfer(PDH_OP_IOR, 20'h0_0323, 8'h00);
        chk(got, 8'hA5);
        xfer(PDH_OP_IOR, 20'h0_0324, 8'h00);
        chk(got, 8'hFF);
        xfer(PDH_OP_DMA, 20'h0_0322, 8'h00);
        chk(got, 8'hFF);
        xfer(PDH_OP_IOW, 20'h0_0320, 8'h69);
        chk(last_wr, 8'h69);
        $display("port test done");
    endtask
    task automatic t_rom();
        xfer(PDH_OP_MEMR, 20'hC_8000, 8'h00);
        chk(got, 8'h00);
        xfer(PDH_OP_MEMR, 20'hC_8FFF, 8'h00);
        chk(got, 8'h00);
        xfer(PDH_OP_MEMR, 20'hC_9000, 8'h00);
        chk(got, 8'hFF);
        xfer(PDH_OP_MEMR, 20'h4_8000, 8'h00);
        chk(got, 8'hFF);
        xfer(PDH_OP_DMA, 20'hC_8003, 8'h5A);
        chk(got, 8'h00);
        $display("rom test done");
    endtask
    task automatic t_irq();
        xfer(PDH_OP_IOW, 20'h0_0322, 8'h00);
        chk(last_cmd, 8'h00);
        done_pulse();
        chk({6'h00, bus_if.irq2, bus_if.irq5}, 8'h01);
        chk({7'h00, irq_seen}, 8'h01);
        xfer(PDH_OP_DMA, 20'h0_0323, 8'h5A);
        chk({6'h00, bus_if.irq2, bus_if.irq5}, 8'h01);
        xfer(PDH_OP_IOR, 20'h0_0321, 8'h00);
        chk(got, 8'h01);
        xfer(PDH_OP_IOW, 20'h0_0321, 8'h00);
        chk({6'h00, bus_if.irq2, bus_if.irq5}, 8'h00);
        irq_sel2 = 1'h1;
        done_pulse();
        chk({6'h00, bus_if.irq2, bus_if.irq5}, 8'h02);
        xfer(PDH_OP_IOW, 20'h0_0321, 8'h00);
        irq_sel2 = 1'h0;
        $display("irq test done");
    endtask
    task automatic t_dma();
        xfer(PDH_OP_IOW, 20'h0_0322, 8'h01);
        chk({7'h00, dma_mode}, 8'h01);
        rd_byte = 8'hC3;
        rd_valid = 1'h1;
        repeat (2) @(negedge clk);
        chk({6'h00, bus_if.drq3, drq_seen}, 8'h03);
        xfer(PDH_OP_DMA, 20'h0_0000, 8'h00);
        chk(got, 8'hC3);
        chk({7'h00, bus_if.drq3}, 8'h00);
        chk({7'h00, rd_valid}, 8'h00);
        xfer(PDH_OP_DMA, 20'h0_0001, 8'h3C);
        chk(last_wr, 8'h3C);
        $display("dma test done");
    endtask
    task automatic t_reset();
        xfer(PDH_OP_IOW, 20'h0_0322, 8'h01);
        rd_valid = 1'h1;
        repeat (2) @(negedge clk);
        chk({6'h00, dma_mode, bus_if.drq3}, 8'h03);
        rst = 1'h1;
        @(negedge clk);
        chk({4'h0, dma_mode, bus_if.drq3, bus_if.irq5, bus_if.dev_d_oe}, 8'h00);
        chk(cmd_byte, 8'h00);
        rst = 1'h0;
        rd_valid = 1'h0;
        xfer(PDH_OP_IOR, 20'h0_0321, 8'h00);
        chk(got, 8'h00);
        $display("reset test done");
    endtask
    initial
    begin
        rst = 1'h1;
        req_valid = 1'h0;
        req_op = PDH_OP_IOR;
        req_addr = 20'h0_0000;
        req_wdata = 8'h00;
        irq_sel2 = 1'h0;
        cfg_in = 8'hA5;
        cmd_done = 1'h0;
        rd_valid = 1'h0;
        rd_byte = 8'h00;
        n_mismatch = 0;
        n_tests = 0;
        cyc = 0;
        repeat (8) @(negedge clk);
        rst = 1'h0;
        t_ports();
        t_rom();
        t_irq();
        t_dma();
        t_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
